//--- verilog/cmd_option_consts.svh
/*
 Named constants of the command-option configuration block: opcodes,
 register addresses, field positions, masks and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CMD_OPTION_CONSTS_SVH
`define CMD_OPTION_CONSTS_SVH

`define OP_READ_ANY     8'h65
`define OP_WRITE_ANY    8'h71
`define OP_30H          8'h30
`define OP_PARAM_ERASE  8'h20
`define OP_SECT_ERASE_A 8'hd8
`define OP_SECT_ERASE_B 8'hdc
`define OP_BULK_ERASE_A 8'h60
`define OP_BULK_ERASE_B 8'hc7
`define OP_LEGACY_RST   8'hf0
`define OP_RST_ENABLE   8'h66
`define OP_RST_EXECUTE  8'h99

`define ADDR_DEFAULTS_OTP 24'h000003
`define ADDR_CONTROLS_LIVE 24'h800003

`define FLD_BLANK_CHECK   5
`define FLD_PAGE_WRAP     4
`define FLD_SMALL_SECTOR  3
`define FLD_RESUME_CLEAR  2
`define FLD_BLOCK_ERASE   1
`define FLD_LEGACY_RESET  0

`define OTP_RESET_VALUE   8'h00
`define OTP_PROG_MASK     8'h3f
`define LIVE_WRITE_MASK   8'h37
`define READ_UNMAPPED     8'h00

`define ADDR_BYTES_LAST   3'h2
`define CNT_ONE_BYTE      3'h1
`define CNT_FOUR_BYTES    3'h4
`define CNT_SATURATE      3'h7
`define BIT_LAST          3'h7
`define PAGE_SMALL_BITS   8

`endif

//--- verilog/cmd_option_pkg.sv
/*
 Types shared by the command-option configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cmd_option_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WDATA  = 3'b010,
    ST_RDATA  = 3'b011,
    ST_IGNORE = 3'b100
  } frame_state_type;

  typedef enum logic [1:0] {
    BC_IDLE   = 2'b00,
    BC_STATUS = 2'b01,
    BC_SCAN   = 2'b10
  } blank_state_type;

  typedef enum logic [1:0] {
    ERASE_PARAM  = 2'b00,
    ERASE_SECTOR = 2'b01,
    ERASE_BULK   = 2'b10
  } erase_kind_type;

endpackage : cmd_option_pkg

//--- verilog/spi_byte_shifter.sv
/*
 Serial byte shifter for an oversampled SPI mode-0 frame.
 Assumes rise/fall strobes come from an already synchronised serial clock
 and that the serial clock is well below a quarter of the system clock.
*/
`timescale 1ns/1ps
`include "cmd_option_consts.svh"

module spi_byte_shifter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       active,
  input  wire logic       rise,
  input  wire logic       fall,
  input  wire logic       din,
  input  wire logic       load_req,
  input  wire logic [7:0] load_data,
  output logic      [7:0] rx_byte,
  output logic            rx_done,
  output logic            dout
);
  logic [2:0] cnt_q;
  logic [6:0] rx_q;
  logic [7:0] tx_q;
  logic       pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 3'h0;
      rx_q    <= 7'h00;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
    end else if (ce) begin
      rx_done <= 1'b0;
      if (!active) begin
        cnt_q <= 3'h0;
      end else if (rise) begin
        cnt_q <= cnt_q + 3'h1;
        rx_q  <= {rx_q[5:0], din};
        if (cnt_q == `BIT_LAST) begin
          rx_byte <= {rx_q, din};
          rx_done <= 1'b1;
        end
      end
    end
  end

  // load waits for the next falling edge so the first bit is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q   <= 8'h00;
      pend_q <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        pend_q <= 1'b0;
      end else if (fall && (pend_q || load_req)) begin
        tx_q   <= load_data;
        pend_q <= 1'b0;
      end else if (fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end else if (load_req) begin
        pend_q <= 1'b1;
      end
    end
  end

  assign dout = tx_q[7];

endmodule : spi_byte_shifter

//--- verilog/page_load_counter.sv
/*
 Program-buffer load address counter with selectable wrap point.
 Assumes the program engine gives a start pulse and one strobe per byte.
*/
`timescale 1ns/1ps
`include "cmd_option_consts.svh"

module page_load_counter #(
  parameter int AW = 9
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          start,
  input  wire logic [AW-1:0] start_addr,
  input  wire logic          strobe,
  input  wire logic          wrap_512,
  output logic      [AW-1:0] addr_q
);
  localparam int SB = `PAGE_SMALL_BITS;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
    end else if (ce) begin
      if (start) begin
        addr_q <= start_addr;
      end else if (strobe && wrap_512) begin
        addr_q <= addr_q + AW'(1);
      end else if (strobe) begin
        addr_q <= {addr_q[AW-1:SB], addr_q[SB-1:0] + SB'(1)};
      end
    end
  end

endmodule : page_load_counter

//--- verilog/command_option_config.sv
/*
 Command-option configuration register pair of a serial flash: one-time
 programmable defaults, live controls, SPI register access, opcode gating,
 blank-check erase sequencing and program-buffer wrap.
 Assumes SCK/CS_N/SI/HW_RESET_N are asynchronous pins, the array-side
 inputs run on SYS_CLK, and SCK stays below a quarter of SYS_CLK.
*/
`timescale 1ns/1ps
`include "cmd_option_consts.svh"

module command_option_config (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  output logic             SO,
  output logic             SO_OE,
  input  wire logic        HW_RESET_N,
  input  wire logic        SECTOR_ERASE_OK,
  input  wire logic        BLANK_WORD_VALID,
  input  wire logic        BLANK_WORD_ZERO,
  input  wire logic        BLANK_READ_END,
  input  wire logic        PAGE_LOAD_START,
  input  wire logic [8:0]  PAGE_LOAD_OFFSET,
  input  wire logic        PAGE_LOAD_STROBE,
  output logic      [8:0]  PAGE_BUF_ADDR,
  output logic             BLANK_CHECK_ON,
  output logic             PAGE_WRAP_512,
  output logic             UNIFORM_SECTORS,
  output logic             RESUME_ON_30H,
  output logic             ERASE_256K,
  output logic             LEGACY_RESET_ON,
  output logic             ERASE_START,
  output logic             ERASE_SKIP,
  output logic      [1:0]  ERASE_KIND,
  output logic      [23:0] ERASE_ADDR,
  output logic             BLANK_READ_REQ,
  output logic             RESUME_PULSE,
  output logic             CLEAR_STATUS_PULSE,
  output logic             SOFT_RESET_PULSE
);
  logic [2:0]  sck_s;
  logic [2:0]  cs_s;
  logic [1:0]  si_s;
  logic [1:0]  hwr_s;
  logic        rise, fall, active, frame_end;
  logic [7:0]  rx_byte;
  logic        rx_done;
  logic        tx_dout;
  logic        load_req;
  logic [7:0]  read_value;

  cmd_option_pkg::frame_state_type state_q;
  logic [7:0]  opcode_q;
  logic [23:0] addr_q;
  logic [2:0]  acnt_q;
  logic [2:0]  nb_q;
  logic        arm_q;

  logic [7:0]  otp_q;
  logic [7:0]  live_q;
  logic [7:0]  live_view;
  logic        wr_otp, wr_live, reload;

  logic        erase_go;
  cmd_option_pkg::erase_kind_type go_kind;
  cmd_option_pkg::blank_state_type bc_q;
  logic        exec_one, exec_four;

  // two flops on every pin before any logic; third flop only for edges
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      si_s  <= 2'h0;
      hwr_s <= 2'h3;
    end else if (CLK_EN) begin
      sck_s <= {sck_s[1:0], SCK};
      cs_s  <= {cs_s[1:0], CS_N};
      si_s  <= {si_s[0], SI};
      hwr_s <= {hwr_s[0], HW_RESET_N};
    end
  end

  assign rise      = sck_s[1] & ~sck_s[2];
  assign fall      = ~sck_s[1] & sck_s[2];
  assign active    = ~cs_s[1];
  assign frame_end = cs_s[1] & ~cs_s[2];

  spi_byte_shifter u_shift (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .ce        (CLK_EN),
    .active    (active),
    .rise      (rise),
    .fall      (fall),
    .din       (si_s[1]),
    .load_req  (load_req),
    .load_data (read_value),
    .rx_byte   (rx_byte),
    .rx_done   (rx_done),
    .dout      (tx_dout)
  );

  assign SO    = tx_dout;
  assign SO_OE = active && (state_q == cmd_option_pkg::ST_RDATA);

  // frame decode; address bytes arrive most significant first
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q  <= cmd_option_pkg::ST_OPCODE;
      opcode_q <= 8'h00;
      addr_q   <= 24'h000000;
      acnt_q   <= 3'h0;
      nb_q     <= 3'h0;
    end else if (CLK_EN) begin
      if (!active) begin
        state_q <= cmd_option_pkg::ST_OPCODE;
        nb_q    <= 3'h0;
        acnt_q  <= 3'h0;
      end else if (rx_done) begin
        if (nb_q != `CNT_SATURATE) begin
          nb_q <= nb_q + 3'h1;
        end
        case (state_q)
          cmd_option_pkg::ST_OPCODE: begin
            opcode_q <= rx_byte;
            if (rx_byte == `OP_READ_ANY || rx_byte == `OP_WRITE_ANY ||
                rx_byte == `OP_PARAM_ERASE ||
                rx_byte == `OP_SECT_ERASE_A ||
                rx_byte == `OP_SECT_ERASE_B) begin
              state_q <= cmd_option_pkg::ST_ADDR;
            end else begin
              state_q <= cmd_option_pkg::ST_IGNORE;
            end
          end
          cmd_option_pkg::ST_ADDR: begin
            addr_q <= {addr_q[15:0], rx_byte};
            acnt_q <= acnt_q + 3'h1;
            if (acnt_q == `ADDR_BYTES_LAST) begin
              if (opcode_q == `OP_WRITE_ANY) begin
                state_q <= cmd_option_pkg::ST_WDATA;
              end else if (opcode_q == `OP_READ_ANY) begin
                state_q <= cmd_option_pkg::ST_RDATA;
              end else begin
                state_q <= cmd_option_pkg::ST_IGNORE;
              end
            end
          end
          cmd_option_pkg::ST_WDATA: state_q <= cmd_option_pkg::ST_IGNORE;
          cmd_option_pkg::ST_RDATA: state_q <= cmd_option_pkg::ST_RDATA;
          cmd_option_pkg::ST_IGNORE: state_q <= cmd_option_pkg::ST_IGNORE;
          default: state_q <= cmd_option_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  // read data reloads every byte so a long read repeats the register
  assign load_req = rx_done && (state_q == cmd_option_pkg::ST_RDATA ||
                    (state_q == cmd_option_pkg::ST_ADDR &&
                     acnt_q == `ADDR_BYTES_LAST &&
                     opcode_q == `OP_READ_ANY));

  always_comb begin
    if (addr_q == `ADDR_DEFAULTS_OTP) begin
      read_value = otp_q;
    end else if (addr_q == `ADDR_CONTROLS_LIVE) begin
      read_value = live_view;
    end else begin
      read_value = `READ_UNMAPPED;
    end
  end

  assign wr_otp  = rx_done && state_q == cmd_option_pkg::ST_WDATA &&
                   addr_q == `ADDR_DEFAULTS_OTP;
  assign wr_live = rx_done && state_q == cmd_option_pkg::ST_WDATA &&
                   addr_q == `ADDR_CONTROLS_LIVE;
  // hardware reset pin held low keeps reloading, like power-on
  assign reload  = SOFT_RESET_PULSE || !hwr_s[1];

  // one-time cells: a write can only set bits; reserved bits stay 0
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      otp_q <= `OTP_RESET_VALUE;
    end else if (CLK_EN && wr_otp) begin
      otp_q <= otp_q | (rx_byte & `OTP_PROG_MASK);
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      live_q <= `OTP_RESET_VALUE & `LIVE_WRITE_MASK;
    end else if (CLK_EN) begin
      if (reload) begin
        live_q <= otp_q & `LIVE_WRITE_MASK;
      end else if (wr_live) begin
        // bits 3, 6 and 7 of the written byte are dropped, so a bad write is harmless
        live_q <= rx_byte & `LIVE_WRITE_MASK;
      end
    end
  end

  // small-sector bit is always the one-time bit itself
  always_comb begin
    live_view = live_q;
    live_view[`FLD_SMALL_SECTOR] = otp_q[`FLD_SMALL_SECTOR];
  end

  assign BLANK_CHECK_ON  = live_q[`FLD_BLANK_CHECK];
  assign PAGE_WRAP_512   = live_q[`FLD_PAGE_WRAP];
  assign UNIFORM_SECTORS = otp_q[`FLD_SMALL_SECTOR];
  assign RESUME_ON_30H   = live_q[`FLD_RESUME_CLEAR];
  assign ERASE_256K      = live_q[`FLD_BLOCK_ERASE];
  assign LEGACY_RESET_ON = live_q[`FLD_LEGACY_RESET];

  page_load_counter #(.AW(9)) u_page (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .ce         (CLK_EN),
    .start      (PAGE_LOAD_START),
    .start_addr (PAGE_LOAD_OFFSET),
    .strobe     (PAGE_LOAD_STROBE),
    .wrap_512   (PAGE_WRAP_512),
    .addr_q     (PAGE_BUF_ADDR)
  );

  // commands act at chip-select release, only with an exact byte count
  assign exec_one  = frame_end && nb_q == `CNT_ONE_BYTE;
  assign exec_four = frame_end && nb_q == `CNT_FOUR_BYTES;

  always_comb begin
    erase_go = 1'b0;
    go_kind  = cmd_option_pkg::ERASE_SECTOR;
    if (exec_four && opcode_q == `OP_PARAM_ERASE && !UNIFORM_SECTORS) begin
      erase_go = 1'b1;
      go_kind  = cmd_option_pkg::ERASE_PARAM;
    end else if (exec_four && (opcode_q == `OP_SECT_ERASE_A ||
                               opcode_q == `OP_SECT_ERASE_B)) begin
      erase_go = 1'b1;
    end else if (exec_one && (opcode_q == `OP_BULK_ERASE_A ||
                              opcode_q == `OP_BULK_ERASE_B)) begin
      erase_go = 1'b1;
      go_kind  = cmd_option_pkg::ERASE_BULK;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      arm_q              <= 1'b0;
      SOFT_RESET_PULSE   <= 1'b0;
      RESUME_PULSE       <= 1'b0;
      CLEAR_STATUS_PULSE <= 1'b0;
    end else if (CLK_EN) begin
      SOFT_RESET_PULSE   <= 1'b0;
      RESUME_PULSE       <= 1'b0;
      CLEAR_STATUS_PULSE <= 1'b0;
      if (frame_end && nb_q != 3'h0) begin
        // any other whole command disarms the reset pair
        arm_q <= exec_one && opcode_q == `OP_RST_ENABLE;
      end
      if (exec_one && opcode_q == `OP_RST_EXECUTE && arm_q) begin
        SOFT_RESET_PULSE <= 1'b1;
      end
      if (exec_one && opcode_q == `OP_LEGACY_RST && LEGACY_RESET_ON) begin
        SOFT_RESET_PULSE <= 1'b1;
      end
      if (exec_one && opcode_q == `OP_30H) begin
        RESUME_PULSE       <= RESUME_ON_30H;
        CLEAR_STATUS_PULSE <= !RESUME_ON_30H;
      end
    end
  end

  // blank-check sequencer; a new erase while busy is ignored
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bc_q        <= cmd_option_pkg::BC_IDLE;
      ERASE_START <= 1'b0;
      ERASE_SKIP  <= 1'b0;
      ERASE_KIND  <= 2'h0;
      ERASE_ADDR  <= 24'h000000;
    end else if (CLK_EN) begin
      ERASE_START <= 1'b0;
      ERASE_SKIP  <= 1'b0;
      case (bc_q)
        cmd_option_pkg::BC_IDLE: begin
          if (erase_go) begin
            ERASE_KIND <= go_kind;
            ERASE_ADDR <= addr_q;
            if (BLANK_CHECK_ON) begin
              bc_q <= cmd_option_pkg::BC_STATUS;
            end else begin
              ERASE_START <= 1'b1;
            end
          end
        end
        cmd_option_pkg::BC_STATUS: begin
          if (!SECTOR_ERASE_OK) begin
            ERASE_START <= 1'b1;
            bc_q        <= cmd_option_pkg::BC_IDLE;
          end else begin
            bc_q <= cmd_option_pkg::BC_SCAN;
          end
        end
        cmd_option_pkg::BC_SCAN: begin
          if (BLANK_WORD_VALID && BLANK_WORD_ZERO) begin
            ERASE_START <= 1'b1;
            bc_q        <= cmd_option_pkg::BC_IDLE;
          end else if (BLANK_READ_END) begin
            ERASE_SKIP <= 1'b1;
            bc_q       <= cmd_option_pkg::BC_IDLE;
          end
        end
        default: bc_q <= cmd_option_pkg::BC_IDLE;
      endcase
      if (SOFT_RESET_PULSE) begin
        bc_q <= cmd_option_pkg::BC_IDLE;
      end
    end
  end

  assign BLANK_READ_REQ = (bc_q == cmd_option_pkg::BC_SCAN);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST || !CLK_EN);

  sequence s_check_passed;
    bc_q == cmd_option_pkg::BC_STATUS && SECTOR_ERASE_OK;
  endsequence
  sequence s_zero_found;
    BLANK_READ_REQ && BLANK_WORD_VALID && BLANK_WORD_ZERO;
  endsequence

  a_otp_never_clears: assert property (
    (($past(otp_q) & ~otp_q) == 8'h00))
    else $error("one-time bit returned to zero");
  a_reset_reload: assert property (
    SOFT_RESET_PULSE |=> live_view == ($past(otp_q) & 8'h3f))
    else $error("live register not reloaded from defaults");
  a_small_sector_ro: assert property (
    $changed(live_view[3]) |-> $changed(otp_q[3]))
    else $error("read-only live bit changed on its own");
  a_erase_no_check: assert property (
    erase_go && !BLANK_CHECK_ON && bc_q == cmd_option_pkg::BC_IDLE
    |=> ERASE_START && !BLANK_READ_REQ)
    else $error("erase without blank check did not start");
  a_failed_prev: assert property (
    bc_q == cmd_option_pkg::BC_STATUS && !SECTOR_ERASE_OK
    |=> ERASE_START && !BLANK_READ_REQ)
    else $error("failed previous erase not erased unconditionally");
  a_scan_zero_hit: assert property (
    s_check_passed ##1 s_zero_found |=> ERASE_START && !ERASE_SKIP)
    else $error("programmed zero did not start erase");
  a_blank_skip: assert property (
    ERASE_SKIP |-> $past(BLANK_READ_REQ && BLANK_READ_END &&
                         !(BLANK_WORD_VALID && BLANK_WORD_ZERO)))
    else $error("skip without a clean blank read");
  a_op30_decode: assert property (
    exec_one && opcode_q == 8'h30
    |=> (RESUME_PULSE == $past(RESUME_ON_30H)) &&
        (CLEAR_STATUS_PULSE == !$past(RESUME_ON_30H)))
    else $error("opcode 30h decoded against select bit");
  a_legacy_ignored: assert property (
    exec_one && opcode_q == 8'hf0 && !LEGACY_RESET_ON && !arm_q
    |=> !SOFT_RESET_PULSE)
    else $error("legacy reset acted while disabled");
  a_reset_pair: assert property (
    exec_one && opcode_q == 8'h99 && arm_q |=> SOFT_RESET_PULSE)
    else $error("66h then 99h did not reset");
  a_wrap_small: assert property (
    PAGE_LOAD_STROBE && !PAGE_LOAD_START && !PAGE_WRAP_512 &&
    PAGE_BUF_ADDR[7:0] == 8'hff
    |=> PAGE_BUF_ADDR == {$past(PAGE_BUF_ADDR[8]), 8'h00})
    else $error("buffer load did not wrap at 256 bytes");

endmodule : command_option_config

//--- verif/spi_host_model.sv
/*
 Host side model: drives whole mode-0 SPI frames into the device.
 Assumes clk is the device system clock; each SCK phase lasts 4 clk.
*/
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap

  // n whole bytes, msb first, taken from the top of tx
  task automatic frame(input int n, input logic [39:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    gap(4);
    for (int i = 0; i < n * 8; i++) begin
      si = tx[39-i];
      gap(4);
      rx = {rx[6:0], so};
      sck = 1'b1;
      gap(4);
      sck = 1'b0;
    end
    gap(4);
    cs_n = 1'b1;
    si = ~si;  // released line must not keep the last bit
    gap(10);
  endtask : frame
endmodule : spi_host_model

//--- verif/command_option_config_bench.sv
/*
 Self-checking bench for the command-option register pair.
 Assumes the host model above and the design's constant header.
*/
`timescale 1ns/1ps
`include "cmd_option_consts.svh"

module command_option_config_bench;
  logic        sys_clk, sys_rst, sck, cs_n, si, so, so_oe, hw_reset_n;
  logic        erase_ok, word_valid, word_zero, read_end;
  logic        pl_start, pl_strobe, read_req, erase_start, erase_skip;
  logic        bc_on, wrap_512, uniform, resume_on, erase_256k, legacy_on;
  logic        resume_p, clear_p, soft_p;
  logic [8:0]  pl_offset, buf_addr;
  logic [1:0]  erase_kind;
  logic [23:0] erase_addr;
  logic [7:0]  rx;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  int          n_start = 0, n_skip = 0, n_resume = 0, n_clear = 0;
  int          n_soft = 0;

  spi_host_model u_host (.clk(sys_clk), .sck(sck), .cs_n(cs_n),
                         .si(si), .so(so));

  command_option_config u_dut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .SCK(sck),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
    .HW_RESET_N(hw_reset_n), .SECTOR_ERASE_OK(erase_ok),
    .BLANK_WORD_VALID(word_valid), .BLANK_WORD_ZERO(word_zero),
    .BLANK_READ_END(read_end), .PAGE_LOAD_START(pl_start),
    .PAGE_LOAD_OFFSET(pl_offset), .PAGE_LOAD_STROBE(pl_strobe),
    .PAGE_BUF_ADDR(buf_addr), .BLANK_CHECK_ON(bc_on),
    .PAGE_WRAP_512(wrap_512), .UNIFORM_SECTORS(uniform),
    .RESUME_ON_30H(resume_on), .ERASE_256K(erase_256k),
    .LEGACY_RESET_ON(legacy_on), .ERASE_START(erase_start),
    .ERASE_SKIP(erase_skip), .ERASE_KIND(erase_kind),
    .ERASE_ADDR(erase_addr), .BLANK_READ_REQ(read_req),
    .RESUME_PULSE(resume_p), .CLEAR_STATUS_PULSE(clear_p),
    .SOFT_RESET_PULSE(soft_p));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // pulses are one cycle wide, so count them as they pass
  always @(posedge sys_clk) begin
    cycles++;
    n_start += (erase_start === 1'b1);
    n_skip += (erase_skip === 1'b1);
    n_resume += (resume_p === 1'b1);
    n_clear += (clear_p === 1'b1);
    n_soft += (soft_p === 1'b1);
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk_vec(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic clr();
    n_start = 0;
    n_skip = 0;
    n_resume = 0;
    n_clear = 0;
    n_soft = 0;
  endtask : clr

  // registers are only reached by the generic read and write
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    u_host.frame(5, {`OP_WRITE_ANY, a, d}, rx);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    u_host.frame(5, {`OP_READ_ANY, a, 8'h00}, rx);
    chk_vec({16'h0000, rx}, {16'h0000, exp});
  endtask : rd

  task automatic cmd(input logic [7:0] op);
    u_host.frame(1, {op, 32'h00000000}, rx);
  endtask : cmd

  task automatic page(input logic [8:0] exp);
    pl_offset = 9'h0ff;
    pl_start = 1'b1;
    @(negedge sys_clk);
    pl_start = 1'b0;
    pl_strobe = 1'b1;
    @(negedge sys_clk);
    pl_strobe = 1'b0;
    @(negedge sys_clk);
    chk_vec({15'h0000, buf_addr}, {15'h0000, exp});
  endtask : page

  // mode 0: no scan expected, 1: scan finds a zero, 2: sector blank
  task automatic erase(input logic [7:0] op, input logic ok, input int mode);
    erase_ok = ok;
    clr();
    // bulk erase is a single-byte command; the others carry an address
    if (op == `OP_BULK_ERASE_A || op == `OP_BULK_ERASE_B)
      u_host.frame(1, {op, 32'h00000000}, rx);
    else
      u_host.frame(4, {op, 24'h040000, 8'h00}, rx);
    if (mode != 0) begin
      for (int k = 0; k < 20 && read_req !== 1'b1; k++)
        @(negedge sys_clk);
      word_valid = (mode == 1);
      word_zero = (mode == 1);
      read_end = (mode == 2);
      @(negedge sys_clk);
      word_valid = 1'b0;
      word_zero = 1'b0;
      read_end = 1'b0;
    end
    u_host.gap(6);
  endtask : erase

  initial begin
    sys_rst = 1'b1;
    hw_reset_n = 1'b1;
    erase_ok = 1'b0;
    word_valid = 1'b0;
    word_zero = 1'b0;
    read_end = 1'b0;
    pl_start = 1'b0;
    pl_strobe = 1'b0;
    pl_offset = 9'h000;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    u_host.gap(4);
    rd(`ADDR_DEFAULTS_OTP, `OTP_RESET_VALUE);
    rd(`ADDR_CONTROLS_LIVE, 8'h00);
    rd(24'h000010, `READ_UNMAPPED);
    wr(`ADDR_CONTROLS_LIVE, 8'hf7);
    rd(`ADDR_CONTROLS_LIVE, 8'h37);
    chk_vec({bc_on, wrap_512, uniform, resume_on, erase_256k, legacy_on},
            24'h37);
    page(9'h100);
    clr();
    cmd(`OP_30H);
    chk_cnt(n_resume, 1);
    cmd(`OP_LEGACY_RST);
    chk_cnt(n_soft, 1);
    rd(`ADDR_CONTROLS_LIVE, 8'h00);
    page(9'h000);
    cmd(`OP_30H);
    chk_cnt(n_clear, 1);
    cmd(`OP_LEGACY_RST);
    chk_cnt(n_soft, 1);
    cmd(`OP_RST_ENABLE);
    cmd(`OP_RST_EXECUTE);
    chk_cnt(n_soft, 2);
    wr(`ADDR_CONTROLS_LIVE, 8'h20);
    erase(`OP_SECT_ERASE_A, 1'b0, 0);
    chk_cnt(n_start, 1);
    chk_vec({22'h0, erase_kind}, 24'h1);
    chk_vec(erase_addr, 24'h040000);
    erase(`OP_SECT_ERASE_B, 1'b1, 1);
    chk_cnt(n_start, 1);
    chk_vec({23'h0, read_req}, 24'h0);
    erase(`OP_PARAM_ERASE, 1'b1, 2);
    chk_cnt(n_skip * 2 + n_start, 2);
    chk_vec({22'h0, erase_kind}, 24'h0);
    erase(`OP_BULK_ERASE_A, 1'b1, 2);
    chk_cnt(n_skip, 1);
    chk_vec({22'h0, erase_kind}, 24'h2);
    wr(`ADDR_CONTROLS_LIVE, 8'h00);
    erase(`OP_BULK_ERASE_B, 1'b1, 0);
    chk_cnt(n_start, 1);
    wr(`ADDR_DEFAULTS_OTP, 8'h2c);
    wr(`ADDR_DEFAULTS_OTP, 8'h00);
    rd(`ADDR_DEFAULTS_OTP, 8'h2c);
    rd(`ADDR_CONTROLS_LIVE, 8'h08);
    chk_vec({23'h0, uniform}, 24'h1);
    hw_reset_n = 1'b0;
    u_host.gap(10);
    hw_reset_n = 1'b1;
    u_host.gap(6);
    rd(`ADDR_CONTROLS_LIVE, 8'h2c);
    erase(`OP_PARAM_ERASE, 1'b1, 0);
    chk_cnt(n_start + n_skip, 0);
    give_verdict();
  end
endmodule : command_option_config_bench
